// ### rtl/pbwg_pkg.sv
// package for the protected bit write guard
// assumes a 32-bit axi4-lite register bus and one system clock
package pbwg_pkg;
    localparam logic [31:0] PBWG_KEY_REG_ADDR = 32'h0000_0000;
    localparam logic [7:0] PBWG_KEY_REG_RESET = 8'h07;
    localparam int PBWG_MODE_LSB = 0;
    localparam int PBWG_BLOCKED_BIT = 2;
    localparam int PBWG_KEY_LSB = 3;
    localparam logic [1:0] PBWG_MODE_OFF = 2'h0;
    localparam logic [1:0] PBWG_MODE_ON = 2'h3;
    localparam logic [4:0] PBWG_KEY_UNLOCK_MODE = 5'h18;
    localparam logic [4:0] PBWG_KEY_OPEN = 5'h13;
    localparam logic [4:0] PBWG_KEY_CLOSE = 5'h15;
    localparam logic [1:0] PBWG_RESP_OKAY = 2'h0;
    localparam logic [1:0] PBWG_RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [1:0] mode;
        logic blocked;
        logic mode_armed;
    } pbwg_state_s;
endpackage : pbwg_pkg

// ### rtl/pbwg_guard.sv
// protected bit write guard: lock key register behind an axi4-lite slave
// assumes one master, synchronous active-high reset, 40 MHz clock
//
// Contract
// - enable field 00 disables the scheme, any other value (reset 11) enables it.
// - the enable field changes only after key 11000 was written first.
// - bit 2 is a read-only status, 1 when protected writes are blocked.
// - key 10011 with the scheme enabled opens protected writes and clears blocked.
// - key 10101 closes protected writes and sets blocked.
// - any other key value in bits 7:3 changes nothing; here a write right after key 11000 still loads the enable field.
//
// Chosen here: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
module pbwg_guard
    import pbwg_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_reset,
    input wire logic [31:0] i_awaddr,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic i_wvalid,
    output logic o_wready,
    output logic [1:0] o_bresp,
    output logic o_bvalid,
    input wire logic i_bready,
    input wire logic [31:0] i_araddr,
    input wire logic i_arvalid,
    output logic o_arready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    output logic o_rvalid,
    input wire logic i_rready,
    output logic o_write_allowed,
    output logic o_scheme_enabled
);

    ////////////////////////////////////////////////////////////////////////////
    // write channel capture
    logic aw_held_r;
    logic w_held_r;
    logic [31:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic do_write;
    pbwg_state_s st_r;
    pbwg_state_s st_nxt;

    function automatic logic addr_hit(input logic [31:0] a);
        addr_hit = (a[31:2] == PBWG_KEY_REG_ADDR[31:2]);
    endfunction : addr_hit

    function automatic logic scheme_on(input logic [1:0] m);
        scheme_on = (m != PBWG_MODE_OFF);
    endfunction : scheme_on

    assign do_write = aw_held_r && w_held_r && !o_bvalid;

    always_ff @(posedge i_clock)
    begin
        if (i_reset)
        begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            o_awready <= 1'b0;
            o_wready <= 1'b0;
            awaddr_r <= 32'h0000_0000;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
        end
        else
        begin
            o_awready <= !aw_held_r && !o_awready && !o_bvalid;
            o_wready <= !w_held_r && !o_wready && !o_bvalid;
            if (i_awvalid && o_awready)
            begin
                aw_held_r <= 1'b1;
                awaddr_r <= i_awaddr;
                o_awready <= 1'b0;
            end
            else if (do_write)
            begin
                aw_held_r <= 1'b0;
            end
            if (i_wvalid && o_wready)
            begin
                w_held_r <= 1'b1;
                wdata_r <= i_wdata;
                wstrb_r <= i_wstrb;
                o_wready <= 1'b0;
            end
            else if (do_write)
            begin
                w_held_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_clock)
    begin
        if (i_reset)
        begin
            o_bvalid <= 1'b0;
            o_bresp <= PBWG_RESP_OKAY;
        end
        else if (do_write)
        begin
            o_bvalid <= 1'b1;
            o_bresp <= addr_hit(awaddr_r) ? PBWG_RESP_OKAY : PBWG_RESP_SLVERR;
        end
        else if (i_bready && o_bvalid)
        begin
            o_bvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // key handling
    logic [4:0] key_w;
    logic [1:0] mode_w;
    logic key_write;
    assign key_w = wdata_r[PBWG_KEY_LSB +: 5];
    assign mode_w = wdata_r[PBWG_MODE_LSB +: 2];
    assign key_write = do_write && addr_hit(awaddr_r) && wstrb_r[0];

    always_comb
    begin
        st_nxt = st_r;
        if (key_write)
        begin
            if (st_r.mode_armed)
            begin
                st_nxt.mode = mode_w;
                st_nxt.mode_armed = 1'b0;
            end
            unique case (key_w)
                PBWG_KEY_UNLOCK_MODE: st_nxt.mode_armed = !st_r.mode_armed;
                PBWG_KEY_OPEN:
                begin
                    if (scheme_on(st_r.mode))
                        st_nxt.blocked = 1'b0;
                end
                PBWG_KEY_CLOSE: st_nxt.blocked = 1'b1;
                default: ;
            endcase
        end
    end

    always_ff @(posedge i_clock)
    begin
        if (i_reset)
        begin
            st_r.mode <= PBWG_KEY_REG_RESET[PBWG_MODE_LSB +: 2];
            st_r.blocked <= PBWG_KEY_REG_RESET[PBWG_BLOCKED_BIT];
            st_r.mode_armed <= 1'b0;
            o_write_allowed <= 1'b0;
            o_scheme_enabled <= 1'b1;
        end
        else
        begin
            st_r <= st_nxt;
            o_write_allowed <= !scheme_on(st_nxt.mode) || !st_nxt.blocked;
            o_scheme_enabled <= scheme_on(st_nxt.mode);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read channel
    logic [7:0] status_byte;
    assign status_byte = {5'h00, !scheme_on(st_r.mode) ? 1'b0 : st_r.blocked,
                          st_r.mode};

    always_ff @(posedge i_clock)
    begin
        if (i_reset)
        begin
            o_arready <= 1'b0;
            o_rvalid <= 1'b0;
            o_rdata <= 32'h0000_0000;
            o_rresp <= PBWG_RESP_OKAY;
        end
        else if (o_rvalid)
        begin
            o_arready <= 1'b0;
            if (i_rready)
                o_rvalid <= 1'b0;
        end
        else if (i_arvalid && o_arready)
        begin
            o_arready <= 1'b0;
            o_rvalid <= 1'b1;
            o_rdata <= addr_hit(i_araddr) ? {24'h000000, status_byte} : 32'h0000_0000;
            o_rresp <= addr_hit(i_araddr) ? PBWG_RESP_OKAY : PBWG_RESP_SLVERR;
        end
        else
        begin
            o_arready <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    sequence s_close_key;
        key_write && key_w == PBWG_KEY_CLOSE;
    endsequence

    a_close_sets_blocked: assert property (@(posedge i_clock) disable iff (i_reset)
        s_close_key |=> st_r.blocked)
        else $error("close key did not set blocked");

    a_open_clears_block: assert property (@(posedge i_clock) disable iff (i_reset)
        key_write && key_w == PBWG_KEY_OPEN && st_r.mode != PBWG_MODE_OFF
        && !st_r.mode_armed |=> !st_r.blocked)
        else $error("open key did not clear blocked");

    a_mode_needs_unlock: assert property (@(posedge i_clock) disable iff (i_reset)
        !st_r.mode_armed |=> $stable(st_r.mode))
        else $error("mode changed without unlock");

    a_unlock_one_shot: assert property (@(posedge i_clock) disable iff (i_reset)
        st_r.mode_armed && key_write && key_w != PBWG_KEY_UNLOCK_MODE |=> !st_r.mode_armed)
        else $error("unlock outlived next write");

    a_bad_key_ignored: assert property (@(posedge i_clock) disable iff (i_reset)
        key_write && !st_r.mode_armed && key_w != PBWG_KEY_OPEN && key_w != PBWG_KEY_CLOSE
        && key_w != PBWG_KEY_UNLOCK_MODE |=> $stable(st_r))
        else $error("unknown key changed state");

    a_allowed_follows: assert property (@(posedge i_clock) disable iff (i_reset)
        o_write_allowed == (st_r.mode == PBWG_MODE_OFF || !st_r.blocked))
        else $error("write allowed out of step");

    a_status_reads: assert property (@(posedge i_clock) disable iff (i_reset)
        i_arvalid && o_arready && addr_hit(i_araddr) && !o_rvalid
        |=> o_rvalid && o_rdata[1:0] == $past(st_r.mode)
        && o_rdata[2] == ($past(st_r.mode) != PBWG_MODE_OFF && $past(st_r.blocked)))
        else $error("status bit read wrong");

    a_write_answers: assert property (@(posedge i_clock) disable iff (i_reset)
        do_write |=> o_bvalid ##0 !aw_held_r)
        else $error("write not answered");

endmodule : pbwg_guard

// ### verification/pbwg_guard_bench.sv
// bench for the protected bit write guard: table of key writes, then edge cases
// assumes the guard answers over axi4-lite at byte address 0x0
`timescale 1ns/1ps
module pbwg_guard_bench
    import pbwg_pkg::*;
;
    logic i_clock = 1'b0;
    logic i_reset = 1'b1;
    logic [31:0] awaddr = '0, wdata = '0, araddr = '0;
    logic [3:0] wstrb = 4'h1;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, allowed, enabled;
    logic [1:0] bresp, rresp, resp;
    logic [31:0] rdata, got;
    int errors = 0;
    int compares = 0;
    // row: written byte, byte read back, write allowed, scheme enabled
    logic [17:0] rows [14] = '{
        {8'h98, 8'h03, 2'b11}, {8'ha8, 8'h07, 2'b01}, {8'h00, 8'h07, 2'b01},
        {8'h04, 8'h07, 2'b01}, {8'hc0, 8'h07, 2'b01}, {8'h00, 8'h00, 2'b10},
        {8'h98, 8'h00, 2'b10}, {8'h03, 8'h00, 2'b10}, {8'hc0, 8'h00, 2'b10},
        {8'h03, 8'h07, 2'b01}, {8'h9b, 8'h03, 2'b11}, {8'hc0, 8'h03, 2'b11},
        {8'h01, 8'h01, 2'b11}, {8'ha9, 8'h05, 2'b01}};
    always #12.5 i_clock = ~i_clock;
    pbwg_guard pbwg_guard_i (.i_clock(i_clock), .i_reset(i_reset), .i_awaddr(awaddr),
        .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata), .i_wstrb(wstrb),
        .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid),
        .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
        .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready),
        .o_write_allowed(allowed), .o_scheme_enabled(enabled));
    ////////////////////////////////////////////////////////////////////////////////
    task chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e)
        begin
            errors++;
            $display("[ERR] %0t got %h expected %h", $time, g, e);
        end
    endtask : chk
    task give_verdict;
        if (errors == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : give_verdict
    task wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge i_clock);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 50; n++)
        begin
            @(posedge i_clock);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bready && bvalid)
            begin
                r = bresp;
                bready <= 1'b0;
                break;
            end
        end
        if (n == 50) chk(32'h1, 32'h0);
    endtask : wr
    task rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge i_clock);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 50; n++)
        begin
            @(posedge i_clock);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rready && rvalid)
            begin
                d = rdata;
                r = rresp;
                rready <= 1'b0;
                break;
            end
        end
        if (n == 50) chk(32'h1, 32'h0);
    endtask : rd
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        #(25 * 4000);
        errors++;
        give_verdict();
    end
    initial
    begin
        repeat (4) @(posedge i_clock);
        i_reset <= 1'b0;
        rd(PBWG_KEY_REG_ADDR, got, resp);
        chk(got, 32'h7);
        chk({30'h0, allowed, enabled}, 32'h1);
        foreach (rows[k])
        begin
            wr(PBWG_KEY_REG_ADDR, {24'h0, rows[k][17:10]}, resp);
            chk({30'h0, resp}, {30'h0, PBWG_RESP_OKAY});
            chk({30'h0, allowed, enabled}, {30'h0, rows[k][1:0]});
            rd(PBWG_KEY_REG_ADDR, got, resp);
            chk({30'h0, resp}, {30'h0, PBWG_RESP_OKAY});
            chk(got, {24'h0, rows[k][9:2]});
        end
        wr(32'h4, 32'h98, resp);
        chk({30'h0, resp}, {30'h0, PBWG_RESP_SLVERR});
        rd(32'h8, got, resp);
        chk({30'h0, resp}, {30'h0, PBWG_RESP_SLVERR});
        chk(got, 32'h0);
        rd(PBWG_KEY_REG_ADDR, got, resp);
        chk(got, 32'h5);
        wstrb <= 4'h0;
        wr(PBWG_KEY_REG_ADDR, 32'h98, resp);
        wstrb <= 4'h1;
        rd(PBWG_KEY_REG_ADDR, got, resp);
        chk(got, 32'h5);
        wr(PBWG_KEY_REG_ADDR, 32'hc0, resp);
        @(posedge i_clock);
        i_reset <= 1'b1;
        repeat (2) @(posedge i_clock);
        i_reset <= 1'b0;
        rd(PBWG_KEY_REG_ADDR, got, resp);
        chk({30'h0, resp}, {30'h0, PBWG_RESP_OKAY});
        chk(got, 32'h7);
        chk({30'h0, allowed, enabled}, 32'h1);
        wr(PBWG_KEY_REG_ADDR, 32'h00, resp);
        rd(PBWG_KEY_REG_ADDR, got, resp);
        chk(got, 32'h7);
        give_verdict();
    end
endmodule : pbwg_guard_bench
